// ==== design/adcoc_consts.svh ====
// Named constants of the converter output-clock and mode control block.
// Assumes inclusion by bare name from the design files only.
`ifndef ADCOC_CONSTS_SVH
`define ADCOC_CONSTS_SVH

// Register addresses carried in the serial frame
`define ADCOC_REG_CFG        4'h1
`define ADCOC_REG_OFS        4'h2
`define ADCOC_REG_FS         4'h3

// Power-on reset values
`define ADCOC_CFG_POR        16'hB2FF
`define ADCOC_OFS_POR        16'h007F
`define ADCOC_FS_POR         16'h807F

// Configuration field positions
`define ADCOC_B_DCS          12
`define ADCOC_B_PHASE        11
`define ADCOC_B_DDR_OFF      10
`define ADCOC_B_SWING        9
`define ADCOC_B_OE           8
`define ADCOC_ADJ_HI         15
`define ADCOC_ADJ_LO         7

// Serial frame layout
`define ADCOC_HDR            12'h001
`define ADCOC_FRAME_LAST     6'h1F

// Timing
`define ADCOC_CLK_NSEC         10
`define ADCOC_T_DLY_SHORT_NSEC 1000000
`define ADCOC_T_DLY_LONG_NSEC  4000000
`define ADCOC_T_CAL_NSEC       100000
`define ADCOC_WORD_DIV       4

`endif

// ==== design/adcoc_pkg.sv ====
// Types shared by the output-clock and mode control block.
// Assumes nothing beyond a SystemVerilog compiler.
package adcoc_pkg;

    // Control sequence states, one-hot
    typedef enum logic [3:0] {
        ST_POR   = 4'h1,
        ST_CAL   = 4'h2,
        ST_RUN   = 4'h4,
        ST_SLEEP = 4'h8
    } adcoc_state_type;

endpackage

// ==== design/adcoc_wr_if.sv ====
// Register write carrier between the serial receiver and the control core.
// Assumes both ends run on sys_clk.
`timescale 1ns/1ns
interface adcoc_wr_if;
    logic        stb;
    logic [3:0]  addr;
    logic [15:0] data;

    modport src (output stb, output addr, output data);
    modport dst (input stb, input addr, input data);
endinterface

// ==== design/adcoc_ser_rx.sv ====
// Serial register-write receiver: 12-bit header, 4-bit address, 16-bit data.
// Assumes synchronised serial levels and a one-cycle serial-clock rise pulse.
`timescale 1ns/1ns
`include "adcoc_consts.svh"
module adcoc_ser_rx
(
    input  wire logic   sys_clk,
    input  wire logic   srst,
    input  wire logic   enable,
    input  wire logic   sclk_rise,
    input  wire logic   sdata,
    input  wire logic   sel_n,
    adcoc_wr_if.src     wr
);
    logic [31:0] shift_reg;
    logic [31:0] shift_next;
    logic [5:0]  count_reg;
    logic        stb_reg;
    logic        last_w;
    logic        hdr_ok_w;

    assign shift_next = {shift_reg[30:0], sdata};
    assign last_w     = (count_reg == `ADCOC_FRAME_LAST);
    assign hdr_ok_w   = (shift_next[31:20] == `ADCOC_HDR);
    assign wr.stb     = stb_reg;
    assign wr.addr    = shift_reg[19:16];
    assign wr.data    = shift_reg[15:0];

    // Frames follow back to back while select stays low
    always_ff @(posedge sys_clk)
    begin
        if (srst || sel_n || !enable)
        begin
            count_reg <= 6'h00;
            stb_reg   <= 1'b0;
        end
        else if (sclk_rise)
        begin
            shift_reg <= shift_next;
            count_reg <= last_w ? 6'h00 : count_reg + 6'h01;
            stb_reg   <= last_w && hdr_ok_w;
        end
        else
        begin
            stb_reg <= 1'b0;
        end
    end
endmodule

// ==== design/adcoc_ctrl.sv ====
// Output-clock, power-down, calibration sequencing and mode control.
// Assumes sample words from logic on sys_clk; every pin is asynchronous.
`timescale 1ns/1ns
`include "adcoc_consts.svh"

// Contract
// - SINGLE_RATE_OUTPUT launch edge follows edge-select pin
// - SINGLE_RATE_OUTPUT data clock equals word rate
// - DDR clock half rate, both edges
// - Floating edge pin selects DDR
// - Sleep pin high: power down, outputs high-Z (outputs stay driven while sleep holds the power-up delay)
// - Sleep waits for running calibration
// - Sleep at power-up holds calibration delay
// - Manual calibration ignored while asleep
// - Floating range pin selects extended control
// - Extended rate from double-rate-disable bit
// - Phase zero normally, bit 11 extended
// - Extended launch edge from edge bit
// - Swing from pin or bit 9
// - Long delay only in normal mode
// - Full scale from pin or register 3
// - Offset only in extended mode
// - Register defaults on power-on reset
// - Duty-cycle correction enabled by default
// - Extended mode ignores configuration pins
// - Bit 10 zero DDR, one SINGLE_RATE_OUTPUT
module adcoc_ctrl
#(
    parameter int WORD_DIV  = `ADCOC_WORD_DIV,
    parameter int DLY_SHORT = (`ADCOC_T_DLY_SHORT_NSEC + `ADCOC_CLK_NSEC - 1) / `ADCOC_CLK_NSEC,
    parameter int DLY_LONG  = (`ADCOC_T_DLY_LONG_NSEC + `ADCOC_CLK_NSEC - 1) / `ADCOC_CLK_NSEC,
    parameter int CAL_CYC   = (`ADCOC_T_CAL_NSEC + `ADCOC_CLK_NSEC - 1) / `ADCOC_CLK_NSEC
)
(
    input  wire logic       sys_clk,
    input  wire logic       srst,
    input  wire logic       sleep_request_pin,
    input  wire logic       launch_edge_select,
    input  wire logic       launch_edge_float,
    input  wire logic       swing_select_pin,
    input  wire logic       range_or_ext_ctrl_select,
    input  wire logic       range_float,
    input  wire logic       cal_delay_select,
    input  wire logic       cal_request_pin,
    input  wire logic       ser_clk,
    input  wire logic       ser_data,
    input  wire logic       ser_sel_n,
    input  wire logic [7:0] sample_a,
    input  wire logic [7:0] sample_b,
    output logic      [7:0] bus_a_out,
    output logic      [7:0] bus_b_out,
    output logic            forwarded_data_clock,
    output logic            out_oe_n,
    output logic            swing_normal,
    output logic            range_normal,
    output logic      [8:0] offset_adjust,
    output logic      [8:0] full_scale_adjust,
    output logic            duty_cycle_correct,
    output logic            cal_running,
    output logic            ext_mode
);
    localparam int PW   = (WORD_DIV > 2) ? $clog2(WORD_DIV) : 1;
    localparam int HALF = WORD_DIV / 2;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic [10:0] sync1_reg;
    logic [10:0] sync2_reg;
    logic        sleep_s;
    logic        edge_s;
    logic        edge_float_s;
    logic        swing_s;
    logic        range_s;
    logic        range_float_s;
    logic        cal_delay_select_s;
    logic        cal_s;
    logic        sclk_s;
    logic        sdata_s;
    logic        sel_n_s;
    logic        sclk_d_reg;
    logic        cal_d_reg;
    logic        sclk_rise_w;
    logic        cal_rise_w;

    always_ff @(posedge sys_clk)
    begin
        sync1_reg <= {sleep_request_pin, launch_edge_select, launch_edge_float,
                      swing_select_pin, range_or_ext_ctrl_select, range_float,
                      cal_delay_select, cal_request_pin, ser_clk, ser_data,
                      ser_sel_n};
        sync2_reg <= sync1_reg;
    end

    assign {sleep_s, edge_s, edge_float_s, swing_s, range_s, range_float_s,
            cal_delay_select_s, cal_s, sclk_s, sdata_s, sel_n_s} = sync2_reg;

    always_ff @(posedge sys_clk)
    begin
        sclk_d_reg <= srst ? 1'b0 : sclk_s;
        cal_d_reg  <= srst ? 1'b1 : cal_s;
    end

    assign sclk_rise_w = sclk_s & ~sclk_d_reg;
    assign cal_rise_w  = cal_s & ~cal_d_reg;

    // ************************************************************
    // Registers written over the serial port
    // ************************************************************
    adcoc_wr_if  wr ();
    logic [15:0] cfg_reg;
    logic [15:0] ofs_reg;
    logic [15:0] fs_reg;
    logic        ext_w;

    assign ext_w = range_float_s;

    // Serial port is live only under extended control
    adcoc_ser_rx u_ser_rx
    (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .enable    (ext_w),
        .sclk_rise (sclk_rise_w),
        .sdata     (sdata_s),
        .sel_n     (sel_n_s),
        .wr        (wr.src)
    );

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            cfg_reg <= `ADCOC_CFG_POR;
            ofs_reg <= `ADCOC_OFS_POR;
            fs_reg  <= `ADCOC_FS_POR;
        end
        else if (wr.stb)
        begin
            if (wr.addr == `ADCOC_REG_CFG)
                cfg_reg <= wr.data;
            if (wr.addr == `ADCOC_REG_OFS)
                ofs_reg <= wr.data;
            if (wr.addr == `ADCOC_REG_FS)
                fs_reg <= wr.data;
        end
    end

    // ************************************************************
    // Effective configuration
    // ************************************************************
    logic       ddr_w;
    logic       rise_w;
    logic       ph90_w;
    logic       swing_w;
    logic       range_w;
    logic [8:0] fs_w;
    logic [8:0] ofs_w;
    logic       dcs_w;
    logic       short_w;
    logic [15:0] fs_por_w;

    // Configuration pins are ignored entirely under extended control
    assign ddr_w    = ext_w ? ~cfg_reg[`ADCOC_B_DDR_OFF] : edge_float_s;
    assign rise_w   = ext_w ? cfg_reg[`ADCOC_B_OE] : edge_s;
    assign ph90_w   = ext_w & cfg_reg[`ADCOC_B_PHASE];
    assign swing_w  = ext_w ? cfg_reg[`ADCOC_B_SWING] : swing_s;
    assign range_w  = ext_w | range_s;
    assign fs_por_w = `ADCOC_FS_POR;
    assign fs_w     = ext_w ? fs_reg[`ADCOC_ADJ_HI:`ADCOC_ADJ_LO]
                            : fs_por_w[`ADCOC_ADJ_HI:`ADCOC_ADJ_LO];
    assign ofs_w    = ext_w ? ofs_reg[`ADCOC_ADJ_HI:`ADCOC_ADJ_LO]
                            : 9'h000;
    assign dcs_w    = ext_w ? cfg_reg[`ADCOC_B_DCS] : 1'b1;
    assign short_w  = ext_w | ~cal_delay_select_s;

    // ************************************************************
    // Power-up delay, calibration and sleep sequencing
    // ************************************************************
    adcoc_pkg::adcoc_state_type st_reg;
    adcoc_pkg::adcoc_state_type st_next;
    logic [31:0] cnt_reg;
    logic [31:0] cnt_next;
    logic [31:0] dly_w;
    logic        dly_done_w;
    logic        cal_done_w;

    assign dly_w      = short_w ? 32'(DLY_SHORT) : 32'(DLY_LONG);
    assign dly_done_w = (cnt_reg >= dly_w - 32'h1);
    assign cal_done_w = (cnt_reg >= 32'(CAL_CYC) - 32'h1);

    always_comb
    begin
        st_next  = st_reg;
        cnt_next = cnt_reg;
        case (st_reg)
            adcoc_pkg::ST_POR:
            begin
                // Delay counter frozen while sleep is held
                if (!sleep_s)
                begin
                    cnt_next = cnt_reg + 32'h1;
                    if (dly_done_w)
                    begin
                        st_next  = adcoc_pkg::ST_CAL;
                        cnt_next = 32'h0;
                    end
                end
            end
            adcoc_pkg::ST_CAL:
            begin
                cnt_next = cnt_reg + 32'h1;
                // Sleep only taken once calibration finishes
                if (cal_done_w)
                begin
                    st_next  = sleep_s ? adcoc_pkg::ST_SLEEP : adcoc_pkg::ST_RUN;
                    cnt_next = 32'h0;
                end
            end
            adcoc_pkg::ST_RUN:
            begin
                if (sleep_s)
                    st_next = adcoc_pkg::ST_SLEEP;
                else if (cal_rise_w)
                    st_next = adcoc_pkg::ST_CAL;
            end
            adcoc_pkg::ST_SLEEP:
            begin
                // No path to calibration: requests dropped here
                if (!sleep_s)
                    st_next = adcoc_pkg::ST_RUN;
            end
            default:
            begin
                st_next  = adcoc_pkg::ST_POR;
                cnt_next = 32'h0;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        st_reg  <= srst ? adcoc_pkg::ST_POR : st_next;
        cnt_reg <= srst ? 32'h0 : cnt_next;
    end

    // ************************************************************
    // Word timing and forwarded data clock
    // ************************************************************
    logic [PW-1:0] ph_reg;
    logic          run_w;
    logic          start_w;
    logic          mid_w;
    logic          fclk_reg;
    logic          fclk_next;
    logic [7:0]    bus_a_reg;
    logic [7:0]    bus_b_reg;
    logic          oe_n_reg;

    assign run_w   = (st_reg == adcoc_pkg::ST_RUN);
    assign start_w = run_w && (ph_reg == PW'(0));
    assign mid_w   = run_w && (ph_reg == PW'(HALF));

    // SINGLE_RATE_OUTPUT: one clock period per word, level set by launch edge
    // DDR: one toggle per word, at launch or mid-word
    always_comb
    begin
        fclk_next = fclk_reg;
        if (start_w)
            fclk_next = ddr_w ? (ph90_w ? fclk_reg : ~fclk_reg) : rise_w;
        else if (mid_w)
            fclk_next = ddr_w ? (ph90_w ? ~fclk_reg : fclk_reg) : ~rise_w;
    end

    // Clock stands still outside RUN, so it halts during calibration
    always_ff @(posedge sys_clk)
    begin
        if (srst || !run_w)
            ph_reg <= PW'(0);
        else
            ph_reg <= (ph_reg == PW'(WORD_DIV - 1)) ? PW'(0) : ph_reg + PW'(1);
    end

    always_ff @(posedge sys_clk)
    begin
        fclk_reg <= srst ? 1'b0 : fclk_next;
        oe_n_reg <= srst ? 1'b0 : (st_next == adcoc_pkg::ST_SLEEP);
    end

    // The word held through sleep is stale pipeline content to the receiver until the first word start in RUN
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            bus_a_reg <= 8'h00;
            bus_b_reg <= 8'h00;
        end
        else if (start_w)
        begin
            bus_a_reg <= sample_a;
            bus_b_reg <= sample_b;
        end
    end

    // ************************************************************
    // Output registers
    // ************************************************************
    logic       swing_reg;
    logic       range_reg;
    logic [8:0] ofs_out_reg;
    logic [8:0] fs_out_reg;
    logic       dcs_reg;
    logic       cal_run_reg;
    logic       ext_reg;

    always_ff @(posedge sys_clk)
    begin
        swing_reg   <= srst ? 1'b1 : swing_w;
        range_reg   <= srst ? 1'b1 : range_w;
        ofs_out_reg <= srst ? 9'h000 : ofs_w;
        fs_out_reg  <= srst ? 9'h100 : fs_w;
        dcs_reg     <= srst ? 1'b1 : dcs_w;
        cal_run_reg <= srst ? 1'b0 : (st_next == adcoc_pkg::ST_CAL);
        ext_reg     <= srst ? 1'b0 : ext_w;
    end

    assign bus_a_out            = bus_a_reg;
    assign bus_b_out            = bus_b_reg;
    assign forwarded_data_clock = fclk_reg;
    assign out_oe_n             = oe_n_reg;
    assign swing_normal         = swing_reg;
    assign range_normal         = range_reg;
    assign offset_adjust        = ofs_out_reg;
    assign full_scale_adjust    = fs_out_reg;
    assign duty_cycle_correct   = dcs_reg;
    assign cal_running          = cal_run_reg;
    assign ext_mode             = ext_reg;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    AST_SDR_EDGE: assert property (start_w && !ddr_w |=> fclk_reg == $past(rise_w))
        else $error("SINGLE_RATE_OUTPUT clock level at word start wrong");
    AST_SDR_MID: assert property (mid_w && !ddr_w |=> fclk_reg == !$past(rise_w))
        else $error("SINGLE_RATE_OUTPUT clock did not complete a period per word");
    AST_DDR_TOGGLE: assert property (start_w && ddr_w && !ph90_w |=> $changed(fclk_reg))
        else $error("DDR clock did not toggle at word start");
    AST_NORM_PHASE: assert property (mid_w && ddr_w && !ext_w |=> $stable(fclk_reg))
        else $error("Normal mode DDR clock moved mid-word");
    AST_SLEEP_HIZ: assert property (st_reg == adcoc_pkg::ST_SLEEP |-> out_oe_n)
        else $error("Outputs driven while asleep");
    AST_CAL_DEFER: assert property (st_reg == adcoc_pkg::ST_CAL && !cal_done_w
                                    |=> st_reg == adcoc_pkg::ST_CAL)
        else $error("Calibration cut short");
    AST_POR_HOLD: assert property (st_reg == adcoc_pkg::ST_POR && sleep_s
                                   |=> $stable(cnt_reg) && st_reg == adcoc_pkg::ST_POR)
        else $error("Power-up delay advanced while asleep");
    AST_CAL_IGNORE: assert property (st_reg == adcoc_pkg::ST_SLEEP && cal_rise_w
                                     |=> !cal_running ##1 !cal_running)
        else $error("Calibration started from sleep");
    // Register must hold across the output stage, else a write races the flop
    AST_EXT_SWING: assert property (ext_w ##1 (ext_w && $stable(cfg_reg))
                                    |-> swing_normal == cfg_reg[`ADCOC_B_SWING])
        else $error("Swing does not follow register in extended mode");
    AST_NORM_OFS: assert property (!ext_w ##1 !ext_w |-> offset_adjust == 9'h000)
        else $error("Offset applied in normal mode");

    COV_DDR_RUN: cover property (start_w && ddr_w);
    COV_SDR_FALL: cover property (start_w && !ddr_w && !rise_w);
    COV_CAL_DEFER: cover property (st_reg == adcoc_pkg::ST_CAL && sleep_s ##1 oe_n_reg);
    COV_EXT_WRITE: cover property (wr.stb && ext_w);
endmodule

// ==== testbench/adcoc_rx_model.sv ====
// Downstream capture model: counts data-clock edges and launched word pairs.
// Assumes the design outputs settle on sys_clk edges; clr restarts the counts.
`timescale 1ns/1ns
module adcoc_rx_model
(
    input  wire logic       sys_clk,
    input  wire logic       clr,
    input  wire logic [7:0] bus_a,
    input  wire logic [7:0] bus_b,
    input  wire logic       fclk,
    input  wire logic       oe_n,
    output int              rises,
    output int              falls,
    output int              words,
    output int              on_rise,
    output int              on_fall
);
    logic [15:0] last_word;
    logic        last_clk;
    logic        new_word;
    logic        clk_up;
    logic        clk_down;

    assign new_word = {bus_a, bus_b} !== last_word;
    assign clk_up   = fclk && !last_clk;
    assign clk_down = !fclk && last_clk;

    // Words seen while released are dropped, never trusted; counting resumes once oe_n is low
    always @(posedge sys_clk)
    begin
        if (clr || oe_n)
        begin
            rises   <= 0;
            falls   <= 0;
            words   <= 0;
            on_rise <= 0;
            on_fall <= 0;
        end
        else
        begin
            rises   <= rises + int'(clk_up);
            falls   <= falls + int'(clk_down);
            words   <= words + int'(new_word);
            on_rise <= on_rise + int'(new_word && clk_up);
            on_fall <= on_fall + int'(new_word && clk_down);
        end
        last_word <= {bus_a, bus_b};
        last_clk  <= fclk;
    end
endmodule

// ==== testbench/adcoc_ctrl_test.sv ====
// Self-checking bench for the output-clock and mode control block.
// Assumes shortened delay parameters and the capture model beside the design.
`timescale 1ns/1ns
module adcoc_ctrl_test;
    localparam int DLY_S = 20;
    localparam int DLY_L = 40;
    localparam int CAL   = 10;

    logic       sys_clk, srst, sleep_request_pin, launch_edge_select, launch_edge_float;
    logic       swing_select_pin, range_or_ext_ctrl_select, range_float, cal_delay_select;
    logic       cal_request_pin, ser_clk, ser_data, ser_sel_n, clr;
    logic [7:0] sample_a, sample_b, bus_a_out, bus_b_out;
    logic       forwarded_data_clock, out_oe_n, swing_normal, range_normal;
    logic [8:0] offset_adjust, full_scale_adjust;
    logic       duty_cycle_correct, cal_running, ext_mode;
    int         rises, falls, words, on_rise, on_fall, fails, samples_checked;

    adcoc_ctrl #(.WORD_DIV(4), .DLY_SHORT(DLY_S), .DLY_LONG(DLY_L), .CAL_CYC(CAL)) adcoc_ctrl_inst
    (
        .sys_clk(sys_clk), .srst(srst), .sleep_request_pin(sleep_request_pin),
        .launch_edge_select(launch_edge_select), .launch_edge_float(launch_edge_float),
        .swing_select_pin(swing_select_pin), .range_float(range_float),
        .range_or_ext_ctrl_select(range_or_ext_ctrl_select),
        .cal_delay_select(cal_delay_select), .cal_request_pin(cal_request_pin),
        .ser_clk(ser_clk), .ser_data(ser_data), .ser_sel_n(ser_sel_n),
        .sample_a(sample_a), .sample_b(sample_b), .bus_a_out(bus_a_out),
        .bus_b_out(bus_b_out), .forwarded_data_clock(forwarded_data_clock),
        .out_oe_n(out_oe_n), .swing_normal(swing_normal), .range_normal(range_normal),
        .offset_adjust(offset_adjust), .full_scale_adjust(full_scale_adjust),
        .duty_cycle_correct(duty_cycle_correct), .cal_running(cal_running),
        .ext_mode(ext_mode)
    );

    adcoc_rx_model adcoc_rx_model_inst
    (
        .sys_clk(sys_clk), .clr(clr), .bus_a(bus_a_out), .bus_b(bus_b_out),
        .fclk(forwarded_data_clock), .oe_n(out_oe_n), .rises(rises), .falls(falls),
        .words(words), .on_rise(on_rise), .on_fall(on_fall)
    );

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("Checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic restart(input logic slp, input logic ext, input logic dly);
        srst = 1'b1;
        sleep_request_pin = slp;
        range_float = ext;
        cal_delay_select = dly;
        repeat (5) @(negedge sys_clk);
        srst = 1'b0;
    endtask

    // Start delay is bounded, then the calibration length
    task automatic wait_cal(input int lo, input int hi);
        int n;
        n = 0;
        while (cal_running !== 1'b1 && n < hi + 50)
        begin
            @(negedge sys_clk);
            n++;
        end
        check(n >= lo && n <= hi, 1);
        n = 0;
        while (cal_running === 1'b1 && n < 200)
        begin
            @(negedge sys_clk);
            n++;
        end
        check(n >= CAL && n <= CAL + 1, 1);
        repeat (4) @(negedge sys_clk);
    endtask

    // Counts over eight word periods after the pins have settled
    task automatic window(input int w, input int r, input int onr, input int onf);
        repeat (6) @(negedge sys_clk);
        clr = 1'b1;
        @(negedge sys_clk);
        clr = 1'b0;
        repeat (32) @(negedge sys_clk);
        check(words, w);
        check(rises, r);
        check(on_rise, onr);
        check(on_fall, onf);
    endtask

    // Link clock only runs inside a frame; data shows the inverse when released
    task automatic ser_write(input logic [3:0] a, input logic [15:0] d);
        logic [31:0] f;
        f = {12'h001, a, d};
        // Offset keeps every link edge clear of sys_clk edges
        #2;
        ser_sel_n = 1'b0;
        for (int i = 31; i >= 0; i--)
        begin
            ser_data = f[i];
            #62 ser_clk = 1'b1;
            #63 ser_clk = 1'b0;
        end
        ser_data = ~f[0];
        ser_sel_n = 1'b1;
        @(negedge sys_clk);
        repeat (8) @(negedge sys_clk);
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_defaults();
        check(ext_mode, 0);
        check(out_oe_n, 0);
        check(swing_normal, 1);
        check(offset_adjust, 9'h000);
        check(full_scale_adjust, 9'h100);
        check(duty_cycle_correct, 1);
        check(cal_running, 0);
    endtask

    task automatic t_normal();
        wait_cal(DLY_L, DLY_L + 6);
        launch_edge_float = 1'b0;
        launch_edge_select = 1'b1;
        window(8, 8, 8, 0);
        launch_edge_select = 1'b0;
        window(8, 8, 0, 8);
        launch_edge_float = 1'b1;
        window(8, 4, 4, 4);
        swing_select_pin = 1'b0;
        range_or_ext_ctrl_select = 1'b0;
        repeat (6) @(negedge sys_clk);
        check(swing_normal, 0);
        check(range_normal, 0);
        check(offset_adjust, 9'h000);
    endtask

    task automatic t_sleep();
        logic bad;
        bad = 1'b0;
        cal_request_pin = 1'b1;
        repeat (5) @(negedge sys_clk);
        cal_request_pin = 1'b0;
        check(cal_running, 1);
        sleep_request_pin = 1'b1;
        while (cal_running === 1'b1)
        begin
            bad |= (out_oe_n !== 1'b0);
            @(negedge sys_clk);
        end
        check(bad, 0);
        repeat (4) @(negedge sys_clk);
        check(out_oe_n, 1);
        cal_request_pin = 1'b1;
        repeat (20)
        begin
            @(negedge sys_clk);
            bad |= (cal_running !== 1'b0);
        end
        check(bad, 0);
        cal_request_pin = 1'b0;
        sleep_request_pin = 1'b0;
        repeat (6) @(negedge sys_clk);
        check(out_oe_n, 0);
        check(cal_running, 0);
    endtask

    task automatic t_sleep_at_power_up();
        logic bad;
        bad = 1'b0;
        restart(1'b1, 1'b0, 1'b0);
        repeat (DLY_S + 20)
        begin
            @(negedge sys_clk);
            bad |= (cal_running !== 1'b0);
        end
        check(bad, 0);
        sleep_request_pin = 1'b0;
        wait_cal(DLY_S - 3, DLY_S + 8);
    endtask

    task automatic t_extended();
        restart(1'b0, 1'b1, 1'b1);
        wait_cal(DLY_S, DLY_S + 6);
        check(ext_mode, 1);
        launch_edge_float = 1'b0;
        launch_edge_select = 1'b0;
        swing_select_pin = 1'b0;
        window(8, 4, 4, 4);
        check(swing_normal, 1);
        check(range_normal, 1);
        ser_write(4'h1, 16'hB5FF);
        check(swing_normal, 0);
        window(8, 8, 8, 0);
        ser_write(4'h1, 16'hBAFF);
        window(8, 4, 0, 0);
        ser_write(4'h2, 16'h8000);
        check(offset_adjust, 9'h100);
        ser_write(4'h3, 16'hFF80);
        check(full_scale_adjust, 9'h1FF);
        ser_write(4'h4, 16'h0000);
        check(offset_adjust, 9'h100);
    endtask

    // ****************************************************************
    // Clock, stimulus and sequence
    // ****************************************************************
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    always @(negedge sys_clk)
    begin
        sample_a <= sample_a + 8'h01;
        sample_b <= sample_b - 8'h01;
    end

    initial
    begin
        {sleep_request_pin, launch_edge_select, cal_request_pin, ser_clk, clr} = 5'h00;
        {launch_edge_float, swing_select_pin, range_or_ext_ctrl_select} = 3'h7;
        {range_float, ser_data, ser_sel_n, srst} = 4'h3;
        {cal_delay_select, sample_a, sample_b, fails, samples_checked} = '0;
        @(negedge sys_clk);
        restart(1'b0, 1'b0, 1'b1);
        t_defaults();
        t_normal();
        t_sleep();
        t_sleep_at_power_up();
        t_extended();
        test_done();
    end

    // The whole sequence needs a few thousand cycles
    initial
    begin
        #100000;
        fails++;
        test_done();
    end
endmodule
